// ---- include/scfg_defines.svh ----
// Constants for the serial configuration command engine.
// Assumes a 200 MHz clock and a byte-wide receive/transmit stream.
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

`define CH_STX            8'h02
`define CH_ETX            8'h03
`define CH_ACK            8'h06
`define CH_NAK            8'h15
`define CH_ZERO           8'h30
`define CH_NINE           8'h39
`define CMD_PROG          24'h999999
`define CMD_DEFAULTS      24'h999998
`define CLK_HZ            200000000
`define GAP_TIMEOUT_S     20
`define GAP_TIMEOUT_CYC   (64'(`GAP_TIMEOUT_S) * `CLK_HZ)
`define BEEP_MS           100
`define BEEP_CYC          (`BEEP_MS * (`CLK_HZ / 1000))
`define FLASH_MS          250
`define FLASH_CYC         (`FLASH_MS * (`CLK_HZ / 1000))
`define DEF_BAUD          4'h3
`define DEF_PARITY        3'h3
`define DEF_STOP          2'h2
`define DEF_DATA          4'h7
`define DEF_TONE          3'h0
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_SERIAL        4'h8
`define REG_LAST          4'hC
`define PAT_NONE          3'h0
`define PAT_ONE           3'h1
`define PAT_THREE         3'h2
`define PAT_LONG          3'h3
`define PAT_RAZZ          3'h4
`define PAT_RAZZ2         3'h5
`define PAT_ONECODE       3'h6

`endif

// ---- include/scfg_pkg.sv ----
// Types shared by the command engine and its indicator sequencer.
// Assumes the defines header is on the include path.
`default_nettype none
package scfg_pkg;
    typedef struct packed {
        logic [3:0] baud;
        logic [2:0] parity;
        logic [1:0] stop;
        logic [3:0] data_bits;
    } serial_cfg_t;

    typedef enum logic [1:0] {
        FAULT_NONE,
        FAULT_LASER,
        FAULT_MOTOR,
        FAULT_MEM
    } fault_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] pattern;
    } beep_req_t;
endpackage
`default_nettype wire

// ---- rtl/indicator_seq.sv ----
// Beeper pattern sequencer: plays a requested count of beeps.
// Assumes a one-cycle request; a new request replaces the current one.
`include "scfg_defines.svh"
`default_nettype none
module indicator_seq #(
    parameter int BEEP_CYC = `BEEP_CYC
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // Request
    input  wire scfg_pkg::beep_req_t req,
    input  wire logic [2:0]          tone_sel,
    // Outputs
    output logic                     beep_on,
    output logic [2:0]               tone,
    output logic                     busy
);
    initial begin
        if (BEEP_CYC < 2) $error("BEEP_CYC too small");
    end

    typedef struct packed {
        logic [31:0] cnt;
        logic [3:0]  phase;
        logic [3:0]  last;
        logic [2:0]  pat;
        logic        on;
        logic [2:0]  tone;
    } seq_t;

    seq_t s_r;
    seq_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (req.valid) begin
            s_nxt.pat   = req.pattern;
            s_nxt.cnt   = '0;
            s_nxt.phase = '0;
            unique case (req.pattern)
                `PAT_ONE:     s_nxt.last = 4'h0;
                `PAT_THREE:   s_nxt.last = 4'h4;
                `PAT_LONG:    s_nxt.last = 4'h3;
                `PAT_RAZZ:    s_nxt.last = 4'h0;
                `PAT_RAZZ2:   s_nxt.last = 4'h2;
                `PAT_ONECODE: s_nxt.last = 4'hA;
                default:      s_nxt.last = 4'h0;
            endcase
        end else if (s_r.pat != `PAT_NONE) begin
            if (s_r.cnt == 32'(BEEP_CYC - 1)) begin
                s_nxt.cnt = '0;
                if (s_r.phase == s_r.last) begin
                    s_nxt.pat = `PAT_NONE;
                end else begin
                    s_nxt.phase = s_r.phase + 4'h1;
                end
            end else begin
                s_nxt.cnt = s_r.cnt + 32'h1;
            end
        end
        // Even phases sound; long beep holds through all phases
        s_nxt.on   = 1'b0;
        s_nxt.tone = tone_sel;
        unique case (s_nxt.pat)
            `PAT_NONE:  s_nxt.on = 1'b0;
            `PAT_LONG:  s_nxt.on = 1'b1;
            `PAT_RAZZ, `PAT_RAZZ2: begin
                s_nxt.on   = ~s_nxt.phase[0];
                s_nxt.tone = 3'h7;
            end
            `PAT_ONECODE: begin
                // Three beeps, pause, then high and low tones
                s_nxt.on = ~s_nxt.phase[0] && (s_nxt.phase != 4'h6);
                if (s_nxt.phase == 4'h8) s_nxt.tone = 3'h5;
                if (s_nxt.phase == 4'hA) s_nxt.tone = 3'h6;
            end
            default:    s_nxt.on = ~s_nxt.phase[0];
        endcase
        // Silent setting suppresses all but the error tone and the one-code tones 5 and 6
        if (tone_sel == 3'h7 && s_nxt.tone == tone_sel && s_nxt.pat != `PAT_RAZZ
            && s_nxt.pat != `PAT_RAZZ2) begin
            s_nxt.on = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign beep_on = s_r.on;
    assign tone    = s_r.tone;
    assign busy    = (s_r.pat != `PAT_NONE);
endmodule
`default_nettype wire

// ---- rtl/serial_config_command_engine.sv ----
// Serial configuration command interpreter with LED and beeper control.
// Assumes byte streams from a UART outside; settings registers over Avalon-MM.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`include "scfg_defines.svh"
`default_nettype none
module serial_config_command_engine #(
    parameter longint GAP_CYC   = `GAP_TIMEOUT_CYC,
    parameter int     FLASH_CYC = `FLASH_CYC,
    parameter int     BEEP_CYC  = `BEEP_CYC,
    parameter int     MAX_DIG   = 6
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Receive byte stream
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_data,
    // Transmit byte stream
    output logic                       tx_valid,
    output logic [7:0]                 tx_data,
    input  wire logic                  tx_ready,
    // Serial port settings in force
    output scfg_pkg::serial_cfg_t      serial_cfg,
    // Scan engine
    input  wire logic                  read_ok,
    input  wire logic                  read_bad,
    input  wire logic                  host_not_ready,
    input  wire logic                  data_pending,
    input  wire logic                  laser_active,
    input  wire logic                  comm_timeout,
    input  wire logic                  selftest_done,
    input  wire scfg_pkg::fault_t      fault,
    input  wire logic                  elec_fault,
    output logic                       motor_laser_en,
    output logic                       decode_en,
    // Indicators
    output logic                       led_green,
    output logic                       led_red,
    output logic                       beep_on,
    output logic [2:0]                 beep_tone,
    // Avalon-MM slave
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest
);
    initial begin
        if (MAX_DIG != 6) $error("MAX_DIG must be 6");
        if (GAP_CYC < 2 || GAP_CYC > 64'hFFFF_FFFF || FLASH_CYC < 2) $error("timing out of range");
    end

    typedef enum logic [2:0] {
        PS_GREEN, PS_BEEP, PS_RUN, PS_FAULT
    } pwr_t;

    typedef struct packed {
        logic                  in_frame;
        logic                  bad_char;
        logic [3:0]            ndig;
        logic [23:0]           digits;
        logic                  prog;
        logic [1:0]            follow;
        logic [31:0]           gap_cnt;
        logic                  tx_pend;
        logic [7:0]            tx_byte;
        scfg_pkg::serial_cfg_t live_cfg;
        scfg_pkg::serial_cfg_t pend_cfg;
        logic [2:0]            tone_sel;
        logic                  beep_en;
        logic                  timeout_beep;
        logic [23:0]           last_cmd;
        logic                  cfg_load;
        pwr_t                  pwr;
        logic [31:0]           flash_cnt;
        logic                  flash_ph;
        logic                  red_pulse;
        logic                  rd_ack;
        logic [31:0]           rdata;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    scfg_pkg::beep_req_t bq;
    logic seq_busy;

    function automatic logic is_digit(input logic [7:0] c);
        return (c >= `CH_ZERO) && (c <= `CH_NINE);
    endfunction

    // Known command codes: session codes plus six-digit settings; the
    // meaning of each setting code is outside this block
    function automatic logic known_code(input logic [3:0] n, input logic [1:0] fol);
        if (n == 4'h1) return fol != 2'h0;
        return n == 4'(MAX_DIG);
    endfunction

    function automatic scfg_pkg::serial_cfg_t default_cfg();
        scfg_pkg::serial_cfg_t c;
        c.baud      = `DEF_BAUD;
        c.parity    = `DEF_PARITY;
        c.stop      = `DEF_STOP;
        c.data_bits = `DEF_DATA;
        return c;
    endfunction

    logic       frame_end;
    logic       frame_ok;
    logic       bus_req;

    assign frame_end = rx_valid && s_r.in_frame && (rx_data == `CH_ETX);
    assign frame_ok  = !s_r.bad_char && (s_r.ndig != 4'h0)
                       && known_code(s_r.ndig, s_r.follow);
    assign bus_req   = avs_read || avs_write;

    always_comb begin
        s_nxt           = s_r;
        bq              = '0;
        s_nxt.red_pulse = 1'b0;
        s_nxt.rd_ack    = 1'b0;

        // ****************************************************
        // Frame assembly
        // ****************************************************
        if (rx_valid) begin
            if (rx_data == `CH_STX) begin
                s_nxt.in_frame = 1'b1;
                s_nxt.bad_char = 1'b0;
                s_nxt.ndig     = '0;
                s_nxt.digits   = '0;
            end else if (s_r.in_frame && rx_data != `CH_ETX) begin
                if (!is_digit(rx_data) || s_r.ndig == 4'(MAX_DIG)) begin
                    s_nxt.bad_char = 1'b1;
                end else begin
                    s_nxt.ndig   = s_r.ndig + 4'h1;
                    s_nxt.digits = {s_r.digits[19:0], rx_data[3:0]};
                end
            end
        end

        // ****************************************************
        // Command execution
        // ****************************************************
        // Clear first so a new reply in the same cycle wins
        if (s_r.tx_pend && tx_ready) begin
            s_nxt.tx_pend = 1'b0;
        end
        if (s_r.prog && s_r.gap_cnt != '0) begin
            s_nxt.gap_cnt = s_r.gap_cnt - 32'h1;
        end
        if (frame_end) begin
            s_nxt.in_frame = 1'b0;
            s_nxt.tx_pend  = 1'b1;
            s_nxt.gap_cnt  = 32'(GAP_CYC);
            s_nxt.last_cmd = s_r.digits;
            if (!s_r.prog) begin
                if (frame_ok && s_r.ndig == 4'h6 && s_r.digits == `CMD_PROG) begin
                    s_nxt.prog     = 1'b1;
                    s_nxt.tx_byte  = `CH_ACK;
                    s_nxt.pend_cfg = s_r.live_cfg;
                    bq             = '{valid: 1'b1, pattern: `PAT_THREE};
                end else begin
                    s_nxt.tx_byte = `CH_NAK;
                end
            end else if (!frame_ok) begin
                s_nxt.tx_byte = `CH_NAK;
                s_nxt.prog    = 1'b0;
                s_nxt.follow  = '0;
                bq            = '{valid: 1'b1, pattern: `PAT_THREE};
            end else begin
                s_nxt.tx_byte = `CH_ACK;
                if (s_r.ndig == 4'h1) begin
                    s_nxt.follow = s_r.follow - 2'h1;
                end else if (s_r.digits == `CMD_PROG) begin
                    s_nxt.prog     = 1'b0;
                    s_nxt.follow   = '0;
                    s_nxt.live_cfg = s_r.pend_cfg;
                    bq             = '{valid: 1'b1, pattern: `PAT_LONG};
                end else if (s_r.digits == `CMD_DEFAULTS) begin
                    s_nxt.pend_cfg = default_cfg();
                    s_nxt.tone_sel = `DEF_TONE;
                    s_nxt.beep_en  = 1'b1;
                end else if (s_r.digits[23:20] == 4'h9) begin
                    s_nxt.follow = 2'h3;
                end
            end
        end else if (s_r.prog && s_r.gap_cnt == 32'h1) begin
            s_nxt.prog    = 1'b0;
            s_nxt.follow  = '0;
            s_nxt.tx_pend = 1'b1;
            s_nxt.tx_byte = `CH_NAK;
            bq            = '{valid: 1'b1, pattern: `PAT_THREE};
        end

        // ****************************************************
        // Power-up, reads and indications
        // ****************************************************
        unique case (s_r.pwr)
            PS_GREEN: begin
                if (selftest_done) begin
                    if (elec_fault || fault != scfg_pkg::FAULT_NONE) begin
                        s_nxt.pwr = PS_FAULT;
                        unique case (fault)
                            scfg_pkg::FAULT_LASER: bq = '{1'b1, `PAT_RAZZ};
                            scfg_pkg::FAULT_MOTOR: bq = '{1'b1, `PAT_RAZZ2};
                            scfg_pkg::FAULT_MEM:   bq = '{1'b1, `PAT_THREE};
                            scfg_pkg::FAULT_NONE:  bq = '{1'b1, `PAT_LONG};
                        endcase
                    end else begin
                        s_nxt.pwr = PS_BEEP;
                        bq        = '{valid: 1'b1, pattern: `PAT_ONE};
                    end
                end
            end
            PS_BEEP:  if (s_r.cfg_load && !seq_busy) s_nxt.pwr = PS_RUN;
            PS_RUN: begin
                if (!s_r.prog && read_ok) begin
                    s_nxt.red_pulse = 1'b1;
                    if (s_r.beep_en) bq = '{valid: 1'b1, pattern: `PAT_ONE};
                end else if (s_r.prog && read_bad) begin
                    bq = '{valid: 1'b1, pattern: `PAT_RAZZ};
                end else if (!s_r.prog && comm_timeout && s_r.timeout_beep) begin
                    bq = '{valid: 1'b1, pattern: `PAT_THREE};
                end
            end
            PS_FAULT: begin
                if (elec_fault && !seq_busy) bq = '{valid: 1'b1, pattern: `PAT_LONG};
            end
        endcase
        s_nxt.cfg_load = (s_r.pwr == PS_BEEP);
        if (s_r.flash_cnt == 32'(FLASH_CYC - 1)) begin
            s_nxt.flash_cnt = '0;
            s_nxt.flash_ph  = ~s_r.flash_ph;
        end else begin
            s_nxt.flash_cnt = s_r.flash_cnt + 32'h1;
        end

        // ****************************************************
        // Register access
        // ****************************************************
        if (bus_req && !s_r.rd_ack) begin
            s_nxt.rd_ack = 1'b1;
            unique case (avs_address)
                `REG_CTRL:   s_nxt.rdata = {26'h0, s_r.timeout_beep, s_r.beep_en,
                                             1'b0, s_r.tone_sel};
                `REG_STATUS: s_nxt.rdata = {24'h0, 2'(s_r.pwr), s_r.follow,
                                             2'h0, s_r.tx_pend, s_r.prog};
                `REG_SERIAL: s_nxt.rdata = {19'h0, s_r.live_cfg};
                `REG_LAST:   s_nxt.rdata = {8'h0, s_r.last_cmd};
                default:     s_nxt.rdata = '0;
            endcase
        end
        // Commit on the accepting edge, when waitrequest is low
        if (avs_write && s_r.rd_ack && avs_address == `REG_CTRL) begin
            s_nxt.tone_sel     = avs_writedata[2:0];
            s_nxt.beep_en      = avs_writedata[4];
            s_nxt.timeout_beep = avs_writedata[5];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r          <= '0;
            s_r.live_cfg <= default_cfg();
            s_r.pend_cfg <= default_cfg();
            s_r.tone_sel <= `DEF_TONE;
            s_r.beep_en  <= 1'b1;
            s_r.pwr      <= PS_GREEN;
        end else begin
            s_r <= s_nxt;
        end
    end

    indicator_seq #(
        .BEEP_CYC (BEEP_CYC)
    ) u_seq (
        .clk      (clk),
        .rstn     (rstn),
        .req      (bq),
        .tone_sel (s_r.tone_sel),
        .beep_on  (beep_on),
        .tone     (beep_tone),
        .busy     (seq_busy)
    );

    // ****************************************************
    // Outputs
    // ****************************************************
    assign tx_valid        = s_r.tx_pend;
    assign tx_data         = s_r.tx_byte;
    assign serial_cfg      = s_r.live_cfg;
    assign motor_laser_en  = (s_r.pwr == PS_RUN);
    assign decode_en       = (s_r.pwr == PS_RUN) && !s_r.prog;
    assign avs_readdata    = s_r.rdata;
    assign avs_waitrequest = bus_req && !s_r.rd_ack;

    always_comb begin
        led_green = 1'b0;
        led_red   = 1'b0;
        unique case (s_r.pwr)
            PS_GREEN: led_green = 1'b1;
            PS_BEEP: begin
                led_green = 1'b1;
                led_red   = seq_busy;
            end
            PS_RUN: begin
                led_green = laser_active;
                led_red   = s_r.red_pulse || (s_r.prog && s_r.flash_ph)
                            || (host_not_ready && data_pending);
            end
            PS_FAULT: begin
                led_green = (fault == scfg_pkg::FAULT_LASER
                             || fault == scfg_pkg::FAULT_MOTOR) && s_r.flash_ph;
                led_red   = (fault == scfg_pkg::FAULT_MOTOR) && s_r.flash_ph;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- verif/scfg_chk.sv ----
// Port-level assertions for the command engine.
// Assumes it is bound onto serial_config_command_engine.
`default_nettype none
module scfg_chk (
    // Clock, reset
    input wire logic                 clk,
    input wire logic                 rstn,
    // Link
    input wire logic                 tx_valid,
    input wire logic [7:0]           tx_data,
    input wire logic                 tx_ready,
    input wire scfg_pkg::serial_cfg_t serial_cfg,
    // Scan engine
    input wire logic                 read_ok,
    input wire logic                 host_not_ready,
    input wire logic                 data_pending,
    input wire logic                 laser_active,
    input wire logic                 decode_en,
    input wire logic                 motor_laser_en,
    input wire logic                 led_green,
    input wire logic                 led_red,
    // Bus
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic                 avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    reply_code_a: assert property (tx_valid |-> tx_data == 8'h06 || tx_data == 8'h15)
        else $error("reply not ack or nak");
    reply_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply dropped");
    bus_wait_a: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
        else $error("no wait state");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    cfg_defer_a: assert property (!decode_en ##1 !decode_en |-> $stable(serial_cfg))
        else $error("settings changed in program mode");
    green_on_a: assert property (laser_active && decode_en |-> led_green)
        else $error("green off with laser active");
    red_hold_a: assert property ((host_not_ready && data_pending && decode_en)[*2] |-> led_red)
        else $error("red off while data held");
    read_flash_a: assert property (read_ok && decode_en |-> ##[0:2] led_red)
        else $error("no red flash on good read");
    prog_motor_a: assert property (tx_valid && !decode_en |-> motor_laser_en)
        else $error("motor off in program mode");
    cover property (tx_valid && tx_data == 8'h15);
    cover property ($fell(decode_en));
    cover property (read_ok && decode_en);
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
// Host serial port: sends framed digit commands, takes replies.
// Assumes byte-level link; bytes go out with one idle cycle between.
`default_nettype none
module host_model (
    // Clock
    input wire logic       clk,
    // Link
    output logic           rx_valid,
    output logic [7:0]     rx_data,
    output logic           tx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rx_valid, rx_data, tx_ready} = '0;
    task automatic put(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~b; // Idle line shows no stale byte
    endtask
    // Digits only, no code-type digit in front
    task automatic send_frame(input string s);
        put(8'h02);
        foreach (s[i]) put(8'(s[i]));
        put(8'h03);
    endtask
    task automatic get_reply(input int dly, output logic [7:0] b, output bit got);
        got = 1'b0;
        for (int i = 0; i < 5000 && !got; i++) begin
            @(posedge clk);
            got = (tx_valid === 1'b1);
        end
        repeat (dly) @(posedge clk);
        tx_ready <= 1'b1;
        @(posedge clk);
        b = tx_data;
        tx_ready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/serial_config_command_engine_tb.sv ----
// Scenario bench for the command engine with a host model.
// Assumes shortened counts: gap 200, flash 8, beep 4 cycles.
`default_nettype none
module serial_config_command_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 200;
    localparam int FL = 8;
    localparam logic [12:0] DEF = {4'h3, 3'h3, 2'h2, 4'h7};
    logic clk, rstn, rx_valid, tx_valid, tx_ready, read_ok, host_not_ready, data_pending;
    logic laser_active, selftest_done, motor_laser_en, decode_en, led_green, led_red, beep_on;
    logic avs_read, avs_write, avs_waitrequest, read_bad, comm_timeout;
    logic [7:0]            rx_data, tx_data;
    logic [2:0]            beep_tone;
    logic [3:0]            avs_address;
    logic [31:0]           avs_writedata, avs_readdata;
    scfg_pkg::serial_cfg_t serial_cfg;
    int                    num_errors, n_compared;
    serial_config_command_engine #(.GAP_CYC(GAP), .FLASH_CYC(FL), .BEEP_CYC(4), .MAX_DIG(6))
        u_serial_config_command_engine (.clk, .rstn, .rx_valid, .rx_data, .tx_valid, .tx_data,
        .tx_ready, .serial_cfg, .read_ok, .read_bad, .host_not_ready, .data_pending,
        .laser_active, .comm_timeout, .selftest_done, .fault(scfg_pkg::FAULT_NONE),
        .elec_fault(1'b0), .motor_laser_en, .decode_en, .led_green, .led_red, .beep_on,
        .beep_tone, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest);
    host_model u_host_model (.clk, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data);
    task automatic test_done;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Held until waitrequest samples low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        bit done;
        done = 1'b0;
        q = '0;
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
                done = 1'b1;
                q = avs_readdata;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!done)
            chk(32'h0, 32'h1, "bus hang");
    endtask
    task automatic cmd(input string s, input logic [7:0] exp, input int dly);
        logic [7:0] b;
        bit         got;
        u_host_model.send_frame(s);
        u_host_model.get_reply(dly, b, got);
        chk({31'h0, got}, 32'h1, {"reply to ", s});
        chk({24'h0, b}, {24'h0, exp}, {"reply byte ", s});
    endtask
    task automatic watch(input int n, input int sel, output int ones);
        ones = 0;
        repeat (n) begin
            @(posedge clk);
            ones += (sel == 0) ? int'(led_red === 1'b1) : int'(beep_on === 1'b1);
        end
    endtask
    task automatic t_power;
        int n;
        selftest_done <= 1'b1;
        chk({31'h0, led_green}, 32'h1, "green at power-up");
        watch(100, 1, n);
        chk({31'h0, n > 0}, 32'h1, "power-up beep");
        for (int i = 0; i < 500 && decode_en !== 1'b1; i++) @(posedge clk);
        chk({31'h0, decode_en}, 32'h1, "ready to scan");
    endtask
    task automatic t_regs;
        logic [31:0] q;
        bus(1'b0, 4'h8, 32'h0, q);
        chk(q, {19'h0, DEF}, "serial defaults");
        bus(1'b1, 4'h0, 32'h35, q);
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h35, "tone select");
        bus(1'b1, 4'h2, 32'hFF, q);
        bus(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
    endtask
    task automatic t_bad;
        int n;
        cmd("999999", 8'h06, 0);
        chk({30'h0, decode_en, motor_laser_en}, 32'h1, "program mode");
        read_bad <= 1'b1;
        watch(4 * FL, 0, n);
        read_bad <= 1'b0;
        chk({31'h0, n > 0 && n < 4 * FL}, 32'h1, "red flashing");
        chk({29'h0, beep_tone}, 32'h7, "error tone");
        cmd("99999:", 8'h15, 5);
        cmd("100113", 8'h15, 0);
    endtask
    task automatic t_session;
        int n;
        cmd("999999", 8'h06, 3);
        cmd("999998", 8'h06, 0);
        cmd("415870", 8'h06, 0);
        chk({19'h0, serial_cfg}, {19'h0, DEF}, "settings deferred");
        cmd("903500", 8'h06, 0);
        cmd("0", 8'h06, 0);
        cmd("7", 8'h06, 2);
        cmd("1", 8'h06, 0);
        cmd("999999", 8'h06, 0);
        watch(60, 1, n);
        chk({31'h0, n > 0}, 32'h1, "exit beep");
        chk({19'h0, serial_cfg}, {19'h0, DEF}, "settings applied");
    endtask
    task automatic t_timeout;
        logic [7:0] b;
        bit         got;
        time        t0;
        cmd("999999", 8'h06, 0);
        t0 = $time;
        u_host_model.get_reply(0, b, got);
        chk({24'h0, b}, 32'h15, "gap nak");
        chk({31'h0, ($time - t0) / 5 >= GAP - 20}, 32'h1, "nak not early");
        chk({31'h0, decode_en}, 32'h1, "session aborted");
    endtask
    task automatic t_leds;
        int n;
        read_ok <= 1'b1;
        @(posedge clk);
        read_ok <= 1'b0;
        watch(4, 0, n);
        chk({31'h0, n > 0}, 32'h1, "read flash");
        host_not_ready <= 1'b1;
        data_pending <= 1'b1;
        repeat (3) @(posedge clk);
        watch(20, 0, n);
        chk(n, 20, "red held");
        host_not_ready <= 1'b0;
        comm_timeout <= 1'b1;
        chk({31'h0, led_green}, 32'h1, "green steady");
        watch(8, 1, n);
        chk({31'h0, n > 0}, 32'h1, "timeout beeps");
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #500000;
        chk(32'h0, 32'h1, "run timeout");
        test_done();
    end
    initial begin
        {rstn, read_ok, read_bad, comm_timeout, host_not_ready, data_pending, selftest_done} = '0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        laser_active = 1'b1;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_power();
        t_regs();
        t_bad();
        t_session();
        t_timeout();
        t_leds();
        test_done();
    end
endmodule
bind serial_config_command_engine scfg_chk u_scfg_chk (.clk, .rstn, .tx_valid, .tx_data,
    .tx_ready, .serial_cfg, .read_ok, .host_not_ready, .data_pending, .laser_active,
    .decode_en, .motor_laser_en, .led_green, .led_red, .avs_read, .avs_write,
    .avs_waitrequest);
`default_nettype wire
